/* File: mcr_consts.vh */
// constants for the monitor channel results block
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH
`define MCR_NUM_CH 5
`define MCR_CH_TEMP 3'h0
`define MCR_CH_VCC 3'h1
`define MCR_CH_LAST 3'h4
`define MCR_CLK_HZ 20000000
`define MCR_FRAME_MS 30
`define MCR_FRAME_MAX_MS 45
`define MCR_FRAME_CYC ((`MCR_CLK_HZ / 1000) * `MCR_FRAME_MS)
`define MCR_SLOT_CYC (`MCR_FRAME_CYC / `MCR_NUM_CH)
`define MCR_MASK_NORMAL 16'hFFFF
`define MCR_MASK_20K 16'hFFF8
`define MCR_TEMP_POS_FS 16'h7FFC
`define MCR_TEMP_NEG_FS 16'h8000
`define MCR_VOLT_FS 16'hFFF8
`define MCR_FLAG_HI 0
`define MCR_FLAG_LO 1
`endif

/* File: mcr_result_mem.v */
// result store: five 16-bit words, registered read port
`default_nettype none
module mcr_result_mem #(
    parameter DEPTH = 5,
    parameter AW = 3
) (
    input wire clock,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [15:0] rd_data
);
    reg [15:0] mem [0:DEPTH-1];
    // both bytes written as one word
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* File: mcr_monitor.v */
// monitor channel results: sequencing, formatting, limit flags, buffers
`include "mcr_consts.vh"
`default_nettype none
module mcr_monitor #(
    parameter FRAME_CYC = `MCR_FRAME_CYC,
    parameter IS_20K = 0
) (
    input wire clock,
    input wire reset_n,
    input wire [15:0] adc_raw,
    input wire adc_done,
    input wire [79:0] limit_alarm_hi,
    input wire [79:0] limit_alarm_lo,
    input wire [79:0] limit_warn_hi,
    input wire [79:0] limit_warn_lo,
    input wire [4:0] int_enable,
    input wire flag_to_buffer_a,
    input wire [4:0] done_clear,
    input wire buffer_a_input,
    input wire buffer_b_input,
    input wire write_protect_pin,
    input wire protect_enable,
    input wire [2:0] rd_channel,
    output reg adc_start,
    output reg [2:0] adc_channel,
    output wire [15:0] rd_result,
    output reg [4:0] conv_done,
    output reg [19:0] limit_flags,
    output reg interrupt,
    output reg buffer_a_open_drain,
    output reg buffer_b_open_drain,
    output reg write_protected
);
    localparam SLOT_CYC = FRAME_CYC / `MCR_NUM_CH;
    localparam ST_START = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_STORE = 2'd2;
    localparam ST_IDLE = 2'd3;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [31:0] slot_cnt_reg;
    reg [15:0] word_reg;
    reg wr_en_reg;
    reg [2:0] wr_ch_reg;
    reg [15:0] fmt;
    reg in_a_s1;
    reg in_a_s2;
    reg in_b_s1;
    reg in_b_s2;
    reg wp_s1;
    reg wp_s2;
    wire [19:0] flags_now;
    wire [4:0] ch_flag;
    wire [4:0] done_next;

    mcr_result_mem #(.DEPTH(`MCR_NUM_CH), .AW(3)) u_mem (
        .clock(clock),
        .wr_en(wr_en_reg),
        .wr_addr(wr_ch_reg),
        .wr_data(word_reg),
        .rd_addr(rd_channel),
        .rd_data(rd_result)
    );

    // keep all 16 bits, zero low 3 bits when IS_20K, clamp to full scale
    always @* begin
        fmt = adc_raw & (IS_20K ? `MCR_MASK_20K : `MCR_MASK_NORMAL);
        if (adc_channel != `MCR_CH_TEMP && fmt > `MCR_VOLT_FS) begin
            fmt = `MCR_VOLT_FS;
        end
        if (adc_channel == `MCR_CH_TEMP && !fmt[15] && fmt > `MCR_TEMP_POS_FS) begin
            fmt = `MCR_TEMP_POS_FS;
        end
    end

    // round-robin slot sequencer
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_START: begin
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (adc_done) begin
                    state_next = ST_STORE;
                end
            end
            ST_STORE: begin
                state_next = ST_IDLE;
            end
            ST_IDLE: begin
                // slot of SLOT_CYC cycles from one start to the next
                // late answer: slot closes right after the store
                if (slot_cnt_reg >= SLOT_CYC - 2) begin
                    state_next = ST_START;
                end
            end
            default: begin
                state_next = ST_START;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= ST_START;
            slot_cnt_reg <= 32'h0000_0000;
            adc_channel <= `MCR_CH_TEMP;
            adc_start <= 1'b0;
            word_reg <= 16'h0000;
            wr_en_reg <= 1'b0;
            wr_ch_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            adc_start <= (state_reg == ST_START);
            wr_en_reg <= 1'b0;
            if (state_reg == ST_START) begin
                slot_cnt_reg <= 32'h0000_0000;
            end else begin
                slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
            end
            if (state_reg == ST_WAIT && adc_done) begin
                word_reg <= fmt;
                wr_en_reg <= 1'b1;
                wr_ch_reg <= adc_channel;
            end
            if (state_reg == ST_IDLE && state_next == ST_START) begin
                adc_channel <= (adc_channel == `MCR_CH_LAST) ? `MCR_CH_TEMP :
                    adc_channel + 3'h1;
            end
        end
    end

    // per-channel stored copy, limit compare and done bit
    genvar g;
    generate
        for (g = 0; g < `MCR_NUM_CH; g = g + 1) begin : g_ch
            reg [15:0] latest_reg;
            wire hit = wr_en_reg && (wr_ch_reg == g);
            wire is_temp = (g == `MCR_CH_TEMP);
            wire [15:0] ah = limit_alarm_hi[16*g +: 16];
            wire [15:0] al = limit_alarm_lo[16*g +: 16];
            wire [15:0] wh = limit_warn_hi[16*g +: 16];
            wire [15:0] wl = limit_warn_lo[16*g +: 16];
            wire sa_hi = $signed(latest_reg) > $signed(ah);
            wire sa_lo = $signed(latest_reg) < $signed(al);
            wire sw_hi = $signed(latest_reg) > $signed(wh);
            wire sw_lo = $signed(latest_reg) < $signed(wl);
            wire ua_hi = latest_reg > ah;
            wire ua_lo = latest_reg < al;
            wire uw_hi = latest_reg > wh;
            wire uw_lo = latest_reg < wl;

            // whole word copied at once, never a byte mix
            always @(posedge clock) begin
                if (!reset_n) begin
                    latest_reg <= 16'h0000;
                end else if (hit) begin
                    latest_reg <= word_reg;
                end
            end

            // temperature signed, voltages unsigned
            assign flags_now[4*g+`MCR_FLAG_HI] = is_temp ? sa_hi : ua_hi;
            assign flags_now[4*g+`MCR_FLAG_LO] = is_temp ? sa_lo : ua_lo;
            assign flags_now[4*g+2+`MCR_FLAG_HI] = is_temp ? sw_hi : uw_hi;
            assign flags_now[4*g+2+`MCR_FLAG_LO] = is_temp ? sw_lo : uw_lo;
            assign ch_flag[g] = |flags_now[4*g +: 4];
            // set wins over clear
            assign done_next[g] = hit ? 1'b1 : (done_clear[g] ? 1'b0 : conv_done[g]);
        end
    endgenerate

    // flags, done bits and interrupt, registered
    always @(posedge clock) begin
        if (!reset_n) begin
            limit_flags <= 20'h0_0000;
            conv_done <= 5'h00;
            interrupt <= 1'b0;
        end else begin
            limit_flags <= flags_now; // one cycle after the stored copy
            conv_done <= done_next;
            interrupt <= |(ch_flag & int_enable);
        end
    end

    // two-stage pin synchronisers, reset to the pins' idle levels
    always @(posedge clock) begin
        if (!reset_n) begin
            in_a_s1 <= 1'b1;
            in_a_s2 <= 1'b1;
            in_b_s1 <= 1'b1;
            in_b_s2 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
        end else begin
            in_a_s1 <= buffer_a_input;
            in_a_s2 <= in_a_s1;
            in_b_s1 <= buffer_b_input;
            in_b_s2 <= in_b_s1;
            wp_s1 <= write_protect_pin;
            wp_s2 <= wp_s1;
        end
    end

    // buffers released at reset; oe low = pin pulled low
    always @(posedge clock) begin
        if (!reset_n) begin
            buffer_a_open_drain <= 1'b1;
            buffer_b_open_drain <= 1'b1;
            write_protected <= 1'b1;
        end else begin
            // pins follow inputs, any flag may also pull pin A low
            buffer_a_open_drain <= in_a_s2 & ~(flag_to_buffer_a & (|flags_now));
            buffer_b_open_drain <= in_b_s2;
            // open pin pulls up and protects only while protect_enable is high, grounded pin frees
            write_protected <= wp_s2 & protect_enable;
        end
    end
endmodule
`default_nettype wire

/* File: mcr_monitor_properties.sv */
// port properties of the monitor block
`default_nettype none
module mcr_monitor_props #(parameter FRAME_CYC = 500) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [15:0] adc_raw,
    input wire logic adc_done,
    input wire logic [79:0] limit_alarm_hi,
    input wire logic [4:0] int_enable,
    input wire logic flag_to_buffer_a,
    input wire logic buffer_b_input,
    input wire logic write_protect_pin,
    input wire logic protect_enable,
    input wire logic adc_start,
    input wire logic [2:0] adc_channel,
    input wire logic [4:0] conv_done,
    input wire logic [19:0] limit_flags,
    input wire logic interrupt,
    input wire logic buffer_a_open_drain,
    input wire logic buffer_b_open_drain,
    input wire logic write_protected
);
    localparam int SLOT_LO = FRAME_CYC / 5 - 2;
    localparam int SLOT_HI = FRAME_CYC / 5 + 2;
    logic [4:0] ch_flag;
    always_comb for (int g = 0; g < 5; g++) ch_flag[g] = |limit_flags[4*g +: 4];
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_order; $changed(adc_channel) |-> adc_channel ==
        ($past(adc_channel) == 3'h4 ? 3'h0 : $past(adc_channel) + 3'h1); endproperty
    a_order: assert property (p_order) else $error("channel order");
    property p_slot; adc_start |-> ##[SLOT_LO:SLOT_HI] adc_start; endproperty
    a_slot: assert property (p_slot) else $error("slot length");
    property p_done; adc_done && !adc_start |-> ##[1:3] conv_done[adc_channel]; endproperty
    a_done: assert property (p_done) else $error("done bit");
    property p_hi; adc_done && adc_channel != 3'h0 && (adc_raw & 16'hfff0) >
        limit_alarm_hi[16*adc_channel +: 16] |-> ##[1:4] limit_flags[4*adc_channel]; endproperty
    a_hi: assert property (p_hi) else $error("alarm high flag");
    property p_irq; $stable(int_enable & ch_flag) [*2] |->
        interrupt == |(int_enable & ch_flag); endproperty
    a_irq: assert property (p_irq) else $error("interrupt");
    property p_buf_b; $stable(buffer_b_input) [*5] |->
        buffer_b_open_drain == buffer_b_input; endproperty
    a_buf_b: assert property (p_buf_b) else $error("buffer b");
    property p_buf_a; (flag_to_buffer_a && |limit_flags) [*3] |-> !buffer_a_open_drain;
    endproperty
    a_buf_a: assert property (p_buf_a) else $error("buffer a");
    property p_wp; $stable({write_protect_pin, protect_enable}) [*5] |->
        write_protected == (write_protect_pin && protect_enable); endproperty
    a_wp: assert property (p_wp) else $error("write protect");
    c_alarm: cover property (|limit_flags);
    c_irq: cover property ($rose(interrupt));
    c_wp: cover property ($fell(write_protected));
endmodule
bind mcr_monitor mcr_monitor_props #(.FRAME_CYC(FRAME_CYC)) u_props (.clock(clock),
    .reset_n(reset_n), .adc_raw(adc_raw), .adc_done(adc_done),
    .limit_alarm_hi(limit_alarm_hi), .int_enable(int_enable),
    .flag_to_buffer_a(flag_to_buffer_a), .buffer_b_input(buffer_b_input),
    .write_protect_pin(write_protect_pin), .protect_enable(protect_enable),
    .adc_start(adc_start), .adc_channel(adc_channel), .conv_done(conv_done),
    .limit_flags(limit_flags), .interrupt(interrupt),
    .buffer_a_open_drain(buffer_a_open_drain), .buffer_b_open_drain(buffer_b_open_drain),
    .write_protected(write_protected));
`default_nettype wire

/* File: mcr_adc_model.sv */
// converter model: answers each start after a set lag
`default_nettype none
module mcr_adc_model (
    input wire logic clock,
    input wire logic start,
    input wire logic [2:0] channel,
    input wire logic [79:0] codes,
    input wire logic [7:0] lag,
    output var logic done,
    output var logic [15:0] raw
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial done = 1'b0;
    initial raw = 16'h5a5a;
    always @(posedge clock) begin
        done <= 1'b0;
        raw <= ~raw;
        cnt <= start ? lag : (cnt > 0 ? cnt - 1 : 0);
        if (cnt == 1) begin
            done <= 1'b1;
            raw <= codes[16*channel +: 16];
        end
    end
endmodule
`default_nettype wire

/* File: mcr_monitor_tb_top.sv */
// bench: monitor block with converter model
`default_nettype none
module mcr_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, reset_n = 0, adc_done, adc_start, flag_a = 0, buf_a = 1, buf_b = 1;
    logic wp_pin = 1, prot = 1, intr, od_a, od_b, wp;
    logic [2:0] rd_ch = 0, adc_ch;
    logic [4:0] int_en = 0, done_clr = 0, conv_done;
    logic [15:0] adc_raw, rd_result;
    logic [19:0] flags;
    logic [79:0] codes = 80'h7abc_0005_8009_ffff_f60f;
    logic [79:0] al_hi = 80'hffff_ffff_ffff_8000_7fff, wn_hi = 80'hffff_ffff_ffff_ffff_7fff;
    logic [79:0] al_lo = 80'h0000_0000_0000_0000_8000, wn_lo = 80'h0000_0100_0000_0000_8000;
    logic [7:0] lag = 8'h03;
    logic [79:0] exp_res = 80'h7abc_0005_8009_fff8_f60f, exp_20k = 80'h7ab8_0000_8008_fff8_f608;
    logic [15:0] rd_20k;
    int err_total = 0, num_checks = 0;
    always #25 clock = ~clock;
    mcr_monitor #(.FRAME_CYC(500)) uut (.clock(clock), .reset_n(reset_n), .adc_raw(adc_raw),
        .adc_done(adc_done), .limit_alarm_hi(al_hi), .limit_alarm_lo(al_lo),
        .limit_warn_hi(wn_hi), .limit_warn_lo(wn_lo), .int_enable(int_en),
        .flag_to_buffer_a(flag_a), .done_clear(done_clr), .buffer_a_input(buf_a),
        .buffer_b_input(buf_b), .write_protect_pin(wp_pin), .protect_enable(prot),
        .rd_channel(rd_ch), .adc_start(adc_start), .adc_channel(adc_ch), .rd_result(rd_result),
        .conv_done(conv_done), .limit_flags(flags), .interrupt(intr),
        .buffer_a_open_drain(od_a), .buffer_b_open_drain(od_b), .write_protected(wp));
    mcr_adc_model adc (.clock(clock), .start(adc_start), .channel(adc_ch), .codes(codes),
        .lag(lag), .done(adc_done), .raw(adc_raw));
    mcr_monitor #(.FRAME_CYC(500), .IS_20K(1)) uut_20k (.clock(clock), .reset_n(reset_n),
        .adc_raw(adc_raw), .adc_done(adc_done), .limit_alarm_hi(al_hi), .limit_alarm_lo(al_lo),
        .limit_warn_hi(wn_hi), .limit_warn_lo(wn_lo), .int_enable(int_en),
        .flag_to_buffer_a(flag_a), .done_clear(done_clr), .buffer_a_input(buf_a),
        .buffer_b_input(buf_b), .write_protect_pin(wp_pin), .protect_enable(prot),
        .rd_channel(rd_ch), .adc_start(), .adc_channel(), .rd_result(rd_20k), .conv_done(),
        .limit_flags(), .interrupt(), .buffer_a_open_drain(), .buffer_b_open_drain(),
        .write_protected());
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_all_done;
        int n;
        n = 0;
        while (conv_done !== 5'h1f && n < 1500) begin
            @(negedge clock);
            n++;
        end
        check("done", conv_done, 20'h0_001f);
        if (n == 1500) report_and_stop();
    endtask
    initial begin
        repeat (12) @(negedge clock);
        reset_n = 1;
        wait_all_done();
        for (int g = 0; g < 5; g++) begin
            rd_ch = g[2:0];
            repeat (2) @(negedge clock);
            check("result", rd_result, exp_res[16*g +: 16]);
            check("host value", rd_result & 16'hfff0, codes[16*g +: 16] & 16'hfff0);
            check("result 20k", rd_20k, exp_20k[16*g +: 16]);
        end
        check("flags", flags, 20'h0_8010);
        int_en = 5'h01;
        repeat (3) @(negedge clock);
        check("irq masked", intr, 1'b0);
        int_en = 5'h02;
        repeat (3) @(negedge clock);
        check("irq", intr, 1'b1);
        check("wp", wp, 1'b1);
        wp_pin = 0;
        flag_a = 1;
        buf_b = 0;
        repeat (5) @(negedge clock);
        check("wp off", wp, 1'b0);
        check("buf a", od_a, 1'b0);
        check("buf b", od_b, 1'b0);
        flag_a = 0;
        buf_b = 1;
        repeat (5) @(negedge clock);
        check("buf a idle", od_a, 1'b1);
        check("buf b idle", od_b, 1'b1);
        done_clr = 5'h1f;
        lag = 8'h50;
        @(negedge clock);
        done_clr = 0;
        wait_all_done();
        report_and_stop();
    end
endmodule
`default_nettype wire
